// file: hw/swar_ctl_if.sv
// Hash and VLAN reach signals shared inside the block
`timescale 1ns/1ns
interface swar_ctl_if;
    import swar_pkg::*;
    logic [MAC_W-1:0] mac;
    swar_hash_t sel;
    logic [IDX_W-1:0] idx;
    logic [PORT_W-1:0] src_port;
    logic [PORTS-1:0] reach;
    modport top (output mac, output sel, output src_port, input idx, input reach);
    modport hash (input mac, input sel, output idx);
    modport vlan (input src_port, output reach);
endinterface

// file: hw/swar_hash.sv
// MAC address to table index hash, direct or CRC mapping
`timescale 1ns/1ns
module swar_hash (
    // Key and index
    swar_ctl_if.hash ctl
);
    import swar_pkg::*;

    function automatic logic [IDX_W-1:0] crc_fold(input logic [MAC_W-1:0] m);
        logic [IDX_W-1:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = MAC_W - 1; i >= 0; i--) begin
            fb = c[IDX_W-1] ^ m[i];
            c = {c[IDX_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
        end
        return c;
    endfunction

    // Direct mapping keeps the low bits, which suit sequential vendor-assigned addresses
    always_comb begin
        if (ctl.sel == HASH_CRC) begin
            ctl.idx = crc_fold(ctl.mac);
        end else begin
            ctl.idx = ctl.mac[IDX_W-1:0];
        end
    end
endmodule

// file: hw/swar_pkg.sv
// Shared constants and types for the switch address resolution block
package swar_pkg;
    localparam int MAC_W = 48;
    localparam int PORTS = 16;
    localparam int PORT_W = 4;
    localparam int GROUPS = 12;
    localparam int IDX_W = 12;
    localparam int WAYS = 2;
    localparam int STAMP_W = 16;
    localparam int GRP_BIT = 40;
    localparam logic [15:0] MIN_LEN = 16'h0040;
    localparam logic [15:0] MAX_LEN = 16'h0600;
    localparam logic [STAMP_W-1:0] AGE_DEFAULT_S = 16'h012C;
    localparam logic [IDX_W-1:0] CRC_POLY = 12'h80F;
    localparam logic [IDX_W-1:0] CRC_INIT = 12'hFFF;
    localparam int CLK_MHZ = 250;
    localparam int SEC_NS = 1000000000;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int SEC_CYCLES = SEC_NS / CLK_NS;

    typedef enum logic {HASH_DIRECT, HASH_CRC} swar_hash_t;
    typedef enum logic [1:0] {CPU_LOOKUP, CPU_FREEZE, CPU_UNFREEZE} swar_cpu_op_t;

    typedef struct packed {
        logic [MAC_W-1:0] mac;
        logic [PORT_W-1:0] port;
        logic [STAMP_W-1:0] stamp;
        logic frozen;
    } swar_ent_t;
endpackage

// file: hw/swar_top.sv
// Address learning, lookup, aging and forwarding decision of the switch
`timescale 1ns/1ns
module swar_top #(
    parameter int SEC_CYC = swar_pkg::SEC_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Stored frame report from the ingress MAC
    input wire logic frm_valid,
    output logic frm_ready,
    input wire logic [swar_pkg::MAC_W-1:0] frm_dst,
    input wire logic [swar_pkg::MAC_W-1:0] frm_src,
    input wire logic [swar_pkg::PORT_W-1:0] frm_port,
    input wire logic [15:0] frm_len,
    input wire logic frm_fcs_ok,
    input wire logic frm_octet_ok,
    // Forwarding decision to the queue manager
    output logic dec_valid,
    input wire logic dec_ready,
    output logic [swar_pkg::PORTS-1:0] dec_mask,
    output logic dec_flood,
    // Configuration
    input wire swar_pkg::swar_hash_t hash_sel,
    input wire logic [swar_pkg::STAMP_W-1:0] age_period_s,
    input wire logic [swar_pkg::GROUPS*swar_pkg::PORTS-1:0] vlan_member,
    // Processor table access
    input wire logic cpu_req,
    input wire swar_pkg::swar_cpu_op_t cpu_op,
    input wire logic [swar_pkg::MAC_W-1:0] cpu_mac,
    output logic cpu_ack,
    output logic cpu_hit,
    output logic [swar_pkg::PORT_W-1:0] cpu_port,
    output logic cpu_frozen
);
    import swar_pkg::*;

    localparam int SC_W = $clog2(SEC_CYC);

    if (SEC_CYC < 2) begin : g_chk
        $error("SEC_CYC must be at least 2");
    end

    typedef enum logic [2:0] {S_IDLE, S_LEARN, S_LOOK, S_OUT, S_CPU} swar_state_t;

    function automatic logic [PORTS-1:0] onehot(input logic [PORT_W-1:0] p);
        return PORTS'(1) << p;
    endfunction

    swar_state_t st_r;
    logic [MAC_W-1:0] dst_r, src_r, cmac_r;
    logic [PORT_W-1:0] port_r;
    swar_cpu_op_t cop_r;
    logic [SC_W-1:0] sec_r;
    logic [STAMP_W-1:0] now_r;
    logic [IDX_W:0] swp_r;
    logic [PORTS-1:0] dec_mask_r;
    logic dec_flood_r, cpu_ack_r, cpu_hit_r, cpu_frozen_r;
    logic [PORT_W-1:0] cpu_port_r;

    swar_ent_t ent_r [WAYS][1<<IDX_W];
    logic [(1<<IDX_W)-1:0] vld_r [WAYS];

    swar_ctl_if ctl ();

    swar_hash u_hash (
        .ctl(ctl.hash)
    );

    swar_vlan u_vlan (
        .ctl(ctl.vlan),
        .member(vlan_member)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Table read side

    logic good, take_frm, sweeping;
    logic [IDX_W-1:0] rd_idx;
    swar_ent_t e0, e1, he;
    logic v0, v1, hit0, hit1, hit, bcast, uni_hit;
    logic [STAMP_W-1:0] age0, age1;
    logic [PORTS-1:0] mask;

    assign good = (frm_len >= MIN_LEN) && (frm_len <= MAX_LEN) && frm_fcs_ok && frm_octet_ok;
    assign frm_ready = (st_r == S_IDLE);
    assign take_frm = frm_valid && frm_ready;
    assign sweeping = (st_r == S_IDLE) && !frm_valid && !(cpu_req && !cpu_ack_r);

    assign ctl.sel = hash_sel;
    assign ctl.src_port = port_r;

    always_comb begin
        case (st_r)
            S_LEARN: ctl.mac = src_r;
            S_LOOK: ctl.mac = dst_r;
            default: ctl.mac = cmac_r;
        endcase
    end

    // Idle cycles lend the read port to the aging sweep
    assign rd_idx = (st_r == S_IDLE) ? swp_r[IDX_W-1:0] : ctl.idx;
    assign e0 = ent_r[0][rd_idx];
    assign e1 = ent_r[1][rd_idx];
    assign v0 = vld_r[0][rd_idx];
    assign v1 = vld_r[1][rd_idx];
    assign hit0 = v0 && (e0.mac == ctl.mac);
    assign hit1 = v1 && (e1.mac == ctl.mac);
    assign hit = hit0 || hit1;
    assign he = hit0 ? e0 : e1;
    assign age0 = now_r - e0.stamp;
    assign age1 = now_r - e1.stamp;

    // Group bit covers the all-ones address too
    assign bcast = dst_r[GRP_BIT];
    assign uni_hit = hit && !bcast;
    assign mask = (uni_hit ? onehot(he.port) : ~onehot(port_r)) & ctl.reach & ~onehot(port_r);

    ////////////////////////////////////////////////////////////////////////////
    // Single write port: every table update passes here, one per cycle

    logic wr_en, wr_way, wr_vld;
    swar_ent_t wr_ent, new_ent;

    assign new_ent = '{mac: src_r, port: port_r, stamp: now_r, frozen: 1'b0};

    always_comb begin
        wr_en = 1'b0;
        wr_way = 1'b0;
        wr_vld = 1'b1;
        wr_ent = e0;
        case (st_r)
            S_IDLE: begin
                wr_way = swp_r[IDX_W];
                wr_ent = wr_way ? e1 : e0;
                wr_vld = 1'b0;
                wr_en = sweeping && (wr_way ? v1 : v0) && !wr_ent.frozen
                        && ((wr_way ? age1 : age0) >= age_period_s);
            end
            S_LEARN: begin
                if (hit) begin
                    wr_en = 1'b1;
                    wr_way = !hit0;
                    wr_ent = he;
                    wr_ent.stamp = now_r;
                    if (!he.frozen) begin
                        wr_ent.port = port_r;
                    end
                end else if (!v0 || !v1) begin
                    wr_en = 1'b1;
                    wr_way = v0;
                    wr_ent = new_ent;
                end else begin
                    wr_en = !(e0.frozen && e1.frozen);
                    wr_way = e0.frozen || (!e1.frozen && (age1 > age0));
                    wr_ent = new_ent;
                end
            end
            S_LOOK: begin
                wr_en = hit;
                wr_way = !hit0;
                wr_ent = he;
                wr_ent.stamp = now_r;
            end
            S_CPU: begin
                wr_en = hit && (cop_r != CPU_LOOKUP);
                wr_way = !hit0;
                wr_ent = he;
                wr_ent.frozen = (cop_r == CPU_FREEZE);
            end
            default: wr_en = 1'b0;
        endcase
    end

    // Two layers of 4K records; contents need no reset since valid bits gate them
    always_ff @(posedge core_clk) begin
        if (clk_en && wr_en) begin
            ent_r[wr_way][rd_idx] <= wr_ent;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vld_r <= '{default: '0};
        end else if (clk_en && wr_en) begin
            vld_r[wr_way][rd_idx] <= wr_vld;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Seconds time base and aging sweep pointer

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_r <= '0;
            now_r <= '0;
        end else if (clk_en) begin
            if (sec_r == SC_W'(SEC_CYC - 1)) begin
                sec_r <= '0;
                now_r <= now_r + 1'b1;
            end else begin
                sec_r <= sec_r + 1'b1;
            end
        end
    end

    // Sweep visits one record per idle cycle, so a full pass takes 8K idle cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            swp_r <= '0;
        end else if (clk_en && sweeping) begin
            swp_r <= swp_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: one frame or one processor request at a time

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
        end else if (clk_en) begin
            case (st_r)
                S_IDLE: begin
                    if (take_frm && good) begin
                        st_r <= S_LEARN;
                    end else if (!frm_valid && cpu_req && !cpu_ack_r) begin
                        st_r <= S_CPU;
                    end
                end
                S_LEARN: st_r <= S_LOOK;
                S_LOOK: st_r <= S_OUT;
                S_OUT: begin
                    if (dec_ready) begin
                        st_r <= S_IDLE;
                    end
                end
                S_CPU: st_r <= S_IDLE;
                default: st_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dst_r <= '0;
            src_r <= '0;
            port_r <= '0;
            cmac_r <= '0;
            cop_r <= CPU_LOOKUP;
        end else if (clk_en && (st_r == S_IDLE)) begin
            if (take_frm && good) begin
                dst_r <= frm_dst;
                src_r <= frm_src;
                port_r <= frm_port;
            end else if (!frm_valid && cpu_req) begin
                cmac_r <= cpu_mac;
                cop_r <= cpu_op;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_mask_r <= '0;
            dec_flood_r <= 1'b0;
        end else if (clk_en && (st_r == S_LOOK)) begin
            dec_mask_r <= mask;
            dec_flood_r <= !uni_hit;
        end
    end

    // Status reflects the record before any freeze change made by the same request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_ack_r <= 1'b0;
            cpu_hit_r <= 1'b0;
            cpu_port_r <= '0;
            cpu_frozen_r <= 1'b0;
        end else if (clk_en) begin
            cpu_ack_r <= (st_r == S_CPU);
            if (st_r == S_CPU) begin
                cpu_hit_r <= hit;
                cpu_port_r <= hit ? he.port : '0;
                cpu_frozen_r <= hit && he.frozen;
            end
        end
    end

    assign dec_valid = (st_r == S_OUT);
    assign dec_mask = dec_mask_r;
    assign dec_flood = dec_flood_r;
    assign cpu_ack = cpu_ack_r;
    assign cpu_hit = cpu_hit_r;
    assign cpu_port = cpu_port_r;
    assign cpu_frozen = cpu_frozen_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    good_start_a: assert property (take_frm && good |=> st_r == S_LEARN)
        else $error("good frame did not start learning");
    bad_drop_a: assert property (take_frm && !good |=> st_r == S_IDLE)
        else $error("bad frame reached lookup");
    direct_hash_a: assert property ((st_r == S_LEARN) && (hash_sel == HASH_DIRECT)
        |-> rd_idx == src_r[IDX_W-1:0])
        else $error("direct hash index wrong");
    learn_empty_a: assert property ((st_r == S_LEARN) && !hit && !(v0 && v1)
        |=> $past(v0) ? vld_r[1][$past(rd_idx)] : vld_r[0][$past(rd_idx)])
        else $error("source not learned into empty slot");
    victim_old_a: assert property ((st_r == S_LEARN) && !hit && v0 && v1 && !e0.frozen
        && !e1.frozen && (age0 > age1) |-> wr_en && !wr_way)
        else $error("younger record replaced");
    unicast_port_a: assert property ((st_r == S_LOOK) && uni_hit && (he.port != port_r)
        && ctl.reach[he.port] |=> dec_valid && (dec_mask == onehot($past(he.port))))
        else $error("known unicast not sent to its port");
    flood_a: assert property ((st_r == S_LOOK) && !uni_hit
        |=> dec_flood && (dec_mask == (~onehot(port_r) & ctl.reach)))
        else $error("flood mask wrong");
    vlan_fence_a: assert property (dec_valid |-> (dec_mask & ~ctl.reach) == '0)
        else $error("port outside shared groups reached");
    isolate_a: assert property (dec_valid && (ctl.reach == '0) |-> dec_mask == '0)
        else $error("isolated port still switched");
    frozen_keep_a: assert property (wr_en && ((st_r == S_IDLE) || ((st_r == S_LEARN)
        && !hit)) |-> !(wr_way ? v1 && e1.frozen : v0 && e0.frozen))
        else $error("frozen record removed or replaced");
    decide_time_a: assert property (take_frm && good |-> ##3 dec_valid)
        else $error("decision late");
    cpu_answer_a: assert property (st_r == S_CPU |=> cpu_ack ##1 !cpu_ack)
        else $error("processor request not answered");

    unicast_c: cover property ((st_r == S_LOOK) && uni_hit);
    flood_c: cover property ((st_r == S_LOOK) && !hit && !bcast);
    replace_c: cover property ((st_r == S_LEARN) && !hit && v0 && v1);
    freeze_c: cover property ((st_r == S_CPU) && hit && (cop_r == CPU_FREEZE));
endmodule

// file: hw/swar_vlan.sv
// Port-based VLAN reach of a source port over overlapping groups
`timescale 1ns/1ns
module swar_vlan (
    // Source port and reach
    swar_ctl_if.vlan ctl,
    // Membership, bit g*PORTS+p set when port p belongs to group g
    input wire logic [swar_pkg::GROUPS*swar_pkg::PORTS-1:0] member
);
    import swar_pkg::*;

    function automatic logic [GROUPS-1:0] groups_of(input logic [GROUPS*PORTS-1:0] m,
                                                    input int p);
        logic [GROUPS-1:0] g;
        for (int i = 0; i < GROUPS; i++) begin
            g[i] = m[i*PORTS+p];
        end
        return g;
    endfunction

    // A port reaches another only through a shared group; trunk ports share many
    for (genvar p = 0; p < PORTS; p++) begin : g_reach
        assign ctl.reach[p] = |(groups_of(member, p) & groups_of(member, int'(ctl.src_port)));
    end
endmodule

// file: test/swar_peer.sv
// Ingress MAC and queue manager stand-in for the address resolution block
`timescale 1ns/1ns
module swar_peer (
    // Clock and stall mode
    input wire logic core_clk,
    input wire logic slow,
    // Stored frame report
    output logic frm_valid,
    input wire logic frm_ready,
    output logic [47:0] frm_dst,
    output logic [47:0] frm_src,
    output logic [3:0] frm_port,
    output logic [15:0] frm_len,
    output logic frm_fcs_ok,
    output logic frm_octet_ok,
    // Decision acceptance
    output logic dec_ready
);
    int seed = 81621;
    initial begin
        frm_valid = 1'b0;
        {frm_dst, frm_src, frm_port, frm_len, frm_fcs_ok, frm_octet_ok} = '0;
        dec_ready = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Queue side stalls at random so decisions must hold
    always @(posedge core_clk) begin
        #1 dec_ready <= slow ? (($random(seed) & 1) != 0) : 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [47:0] d, s, input logic [3:0] p,
                        input logic [15:0] n, input logic f, o);
        int k;
        @(posedge core_clk);
        #1;
        {frm_dst, frm_src, frm_port, frm_len, frm_fcs_ok, frm_octet_ok} = {d, s, p, n, f, o};
        frm_valid = 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (frm_ready !== 1'b1 && k < 500);
        #1;
        frm_valid = 1'b0;
        // Released address, port and length lines carry junk so a stale value is never mistaken for live data
        {frm_dst, frm_src, frm_port, frm_len} = ~{frm_dst, frm_src, frm_port, frm_len};
    endtask
endmodule

// file: test/test_swar_top.sv
// Self-checking bench for the switch address resolution block
`timescale 1ns/1ns
module test_swar_top;
    import swar_pkg::*;
    localparam int SC = 16;
    logic core_clk, rst_n, clk_en, frm_valid, frm_ready, frm_fcs_ok, frm_octet_ok;
    logic dec_valid, dec_ready, dec_flood, cpu_req, cpu_ack, cpu_hit, cpu_frozen, slow;
    logic [MAC_W-1:0] frm_dst, frm_src, cpu_mac;
    logic [PORT_W-1:0] frm_port, cpu_port;
    logic [15:0] frm_len;
    logic [PORTS-1:0] dec_mask;
    logic [STAMP_W-1:0] age_period_s;
    logic [GROUPS*PORTS-1:0] vlan_member;
    swar_hash_t hash_sel;
    swar_cpu_op_t cpu_op;
    logic [16:0] dq[$];
    logic [5:0] cq[$];
    logic [5:0] ce;
    logic [3:0] tbl[logic [47:0]];
    int seed = 81621;
    int checks = 0;
    int err_total = 0;
    int cyc = 0;

    swar_top #(.SEC_CYC(SC)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_dst(frm_dst), .frm_src(frm_src),
        .frm_port(frm_port), .frm_len(frm_len), .frm_fcs_ok(frm_fcs_ok),
        .frm_octet_ok(frm_octet_ok), .dec_valid(dec_valid), .dec_ready(dec_ready),
        .dec_mask(dec_mask), .dec_flood(dec_flood), .hash_sel(hash_sel),
        .age_period_s(age_period_s), .vlan_member(vlan_member), .cpu_req(cpu_req),
        .cpu_op(cpu_op), .cpu_mac(cpu_mac), .cpu_ack(cpu_ack), .cpu_hit(cpu_hit),
        .cpu_port(cpu_port), .cpu_frozen(cpu_frozen));
    swar_peer u_peer (.core_clk(core_clk), .slow(slow), .frm_valid(frm_valid),
        .frm_ready(frm_ready), .frm_dst(frm_dst), .frm_src(frm_src), .frm_port(frm_port),
        .frm_len(frm_len), .frm_fcs_ok(frm_fcs_ok), .frm_octet_ok(frm_octet_ok),
        .dec_ready(dec_ready));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [47:0] ma(input int i);
        return {8'h02, 28'h0000000, 12'h100 + 12'(i)};
    endfunction
    // Same low twelve bits, so one direct index
    function automatic logic [47:0] mb(input int i);
        return {8'h02, 28'(i + 1), 12'h7A5};
    endfunction
    function automatic logic [16:0] want(input logic [47:0] d, input logic [3:0] p);
        logic [15:0] r, me;
        r = '0;
        me = 16'h0001 << p;
        for (int g = 0; g < GROUPS; g++)
            if (vlan_member[g*PORTS+p]) r |= vlan_member[g*PORTS +: PORTS];
        if (!d[GRP_BIT] && tbl.exists(d)) return {1'b0, (16'h0001 << tbl[d]) & r & ~me};
        return {1'b1, r & ~me};
    endfunction
    task automatic chk(input logic [47:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic frame(input logic [47:0] d, s, input logic [3:0] p,
                         input logic [15:0] n = 16'h0040, input logic f = 1'b1, o = 1'b1);
        if (n >= MIN_LEN && n <= MAX_LEN && f && o) begin
            tbl[s] = p;
            dq.push_back(want(d, p));
        end
        u_peer.send(d, s, p, n, f, o);
    endtask
    task automatic cpu(input swar_cpu_op_t op, input logic [47:0] m, input logic [5:0] e);
        int k;
        cq.push_back(e);
        @(posedge core_clk);
        #1;
        cpu_op = op;
        cpu_mac = m;
        cpu_req = 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (cpu_ack !== 1'b1 && k < 50);
        #1;
        cpu_req = 1'b0;
    endtask
    task automatic drain();
        for (int k = 0; k < 300 && dq.size() != 0; k++)
            @(posedge core_clk);
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Result watcher
    always @(posedge core_clk) begin
        if (clk_en === 1'b1 && dec_valid === 1'b1 && dec_ready === 1'b1) begin
            if (dq.size() == 0) chk(1'b1, 1'b0);
            else chk({dec_flood, dec_mask}, dq.pop_front());
        end
        if (clk_en === 1'b1 && cpu_ack === 1'b1) begin
            ce = cq.pop_front();
            chk(cpu_hit, ce[5]);
            if (ce[5]) chk({cpu_port, cpu_frozen}, ce[4:0]);
        end
    end
    // Hang guard, sized well past the aging wait
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk_en, rst_n, cpu_req, slow, cpu_mac} = {1'b1, 1'b0, 1'b0, 1'b0, 48'h0};
        cpu_op = CPU_LOOKUP;
        hash_sel = HASH_DIRECT;
        age_period_s = AGE_DEFAULT_S;
        // Port 7 and 8 are trunks, port 15 is in no group
        vlan_member = (GROUPS * PORTS)'({16'h0180, 16'h7F00, 16'h00FF});
        repeat (4) @(posedge core_clk);
        #1 rst_n = 1'b1;
        // Broadcast, group bit, isolated port, then learned unicast across groups
        frame({48{1'b1}}, ma(1), 4'h0);
        frame(48'h0100_0000_0001, ma(2), 4'h8);
        frame({48{1'b1}}, ma(3), 4'hF);
        frame(ma(1), ma(4), 4'h5);
        frame(ma(2), ma(4), 4'h5);
        frame(ma(2), ma(5), 4'h7);
        frame(ma(1), ma(3), 4'hF);
        frame(ma(4), ma(4), 4'h5);
        // Errored frames, then both length limits
        frame(ma(1), ma(6), 4'h2, 16'h003F);
        frame(ma(1), ma(6), 4'h2, 16'h0601);
        frame(ma(1), ma(6), 4'h2, 16'h0040, 1'b0);
        frame(ma(1), ma(6), 4'h2, 16'h0600, 1'b1, 1'b0);
        frame(ma(6), ma(1), 4'h0, 16'h0600);
        frame(ma(6), ma(1), 4'h0, 16'h0040);
        // Enable low just after the take must hold the sequencer in learning
        clk_en = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 chk(frm_ready, 1'b0);
        clk_en = 1'b1;
        // Back-to-back random traffic with a stalling queue side
        slow = 1'b1;
        for (int i = 0; i < 40; i++)
            frame(($random(seed) & 7) == 0 ? {48{1'b1}} : ma($unsigned($random(seed)) % 8),
                  ma($unsigned($random(seed)) % 8), 4'($random(seed)),
                  16'h0040 + 16'($unsigned($random(seed)) % 1473));
        // Third address on a full index replaces the older record
        for (int i = 0; i < 3; i++) begin
            frame({48{1'b1}}, mb(i), 4'h1);
            repeat (2 * SC + 8) @(posedge core_clk);
        end
        tbl.delete(mb(0));
        frame(mb(1), ma(1), 4'h0);
        frame(mb(2), ma(1), 4'h0);
        frame(mb(0), ma(1), 4'h0);
        drain();
        // Processor access while idle
        cpu(CPU_LOOKUP, mb(2), {1'b1, 4'h1, 1'b0});
        cpu(CPU_LOOKUP, mb(0), 6'h00);
        cpu(CPU_FREEZE, mb(1), {1'b1, 4'h1, 1'b0});
        cpu(CPU_LOOKUP, mb(1), {1'b1, 4'h1, 1'b1});
        cpu(CPU_UNFREEZE, mb(1), {1'b1, 4'h1, 1'b1});
        cpu(CPU_FREEZE, 48'h0200_0000_0ABC, 6'h00);
        // CRC index, then aging with one frozen record
        hash_sel = HASH_CRC;
        tbl.delete();
        frame({48{1'b1}}, ma(9), 4'h2);
        frame({48{1'b1}}, ma(10), 4'h3);
        frame(ma(9), ma(10), 4'h3);
        drain();
        cpu(CPU_FREEZE, ma(10), {1'b1, 4'h3, 1'b0});
        age_period_s = 16'h0002;
        repeat (17000) @(posedge core_clk);
        tbl.delete();
        tbl[ma(10)] = 4'h3;
        frame(ma(9), ma(11), 4'h1);
        frame(ma(10), ma(11), 4'h1);
        drain();
        chk(dq.size(), 0);
        results();
    end
endmodule
